//--- verilog/spdif_in_pkg.sv
// constants, register map and state types of the biphase transmitter input stage
package spdif_in_pkg;
	localparam int SAMPLE_W = 24;
	localparam int FIFO_W = 48;
	localparam int FIFO_DEPTH = 32;
	localparam int LEVEL_W = 6;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_LEFT = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_RIGHT = 8'h0C;
	localparam int CTRL_BITS = 6;
	localparam int STATUS_OVF_BIT = 16;

	localparam logic [1:0] FMT_I2S = 2'h0;
	localparam logic [1:0] FMT_LEFT_JUST = 2'h1;
	localparam logic [1:0] FMT_RIGHT_JUST = 2'h2;

	localparam logic [1:0] WSEL_16 = 2'h0;
	localparam logic [1:0] WSEL_18 = 2'h1;
	localparam logic [1:0] WSEL_20 = 2'h2;
	localparam logic [1:0] WSEL_24 = 2'h3;
	localparam logic [5:0] WORD_16 = 6'h10;
	localparam logic [5:0] WORD_18 = 6'h12;
	localparam logic [5:0] WORD_20 = 6'h14;
	localparam logic [5:0] WORD_24 = 6'h18;
	localparam logic [5:0] HALF_FRAME_BITS = 6'h20;
	localparam logic [5:0] BIT_COUNT_MAX = 6'h3F;

	// oversampling ratio over biphase clock rate (128 x frame rate)
	localparam logic [1:0] OS_DIV_256 = 2'h2;
	localparam logic [1:0] OS_DIV_384 = 2'h3;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [DATA_W-1:0] prdata;
	} apb_rsp_type;

	typedef struct packed {
		logic ratio_384;
		logic [1:0] width_sel;
		logic [1:0] format;
		logic enable;
	} ctrl_type;

	typedef struct packed {
		logic [2:0] bclk_sync;
		logic [1:0] lr_sync;
		logic [1:0] data_sync;
		logic [2:0] osc_sync;
		logic lr_prev;
		logic started;
		logic [5:0] bit_count;
		logic [SAMPLE_W-1:0] shift;
		logic [SAMPLE_W-1:0] left_word;
		logic left_valid;
		logic [1:0] div_count;
		logic biphase_tick;
		logic overflow;
		ctrl_type ctrl;
		apb_rsp_type rsp;
	} top_state_type;

	localparam top_state_type TOP_RESET = '0;
endpackage : spdif_in_pkg

//--- verilog/spdif_tx_serial_input_formatter.sv
// serial audio input formatter, sample fifo and oversampling clock divider
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module sample_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 32,
	parameter int LVL_W = 6
) (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data,
	output logic [LVL_W-1:0] o_level
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [LVL_W-1:0] FULL_LEVEL = LVL_W'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [LVL_W-1:0] level;
	} fifo_state_type;

	fifo_state_type r;
	fifo_state_type next_r;
	logic push;
	logic pop;

	// level is one bit wider than the pointers, so full and empty differ
	assign o_in_ready = (r.level != FULL_LEVEL);
	assign o_out_valid = (r.level != '0);
	assign o_out_data = r.mem[r.rd_ptr];
	assign o_level = r.level;

	always_comb begin
		next_r = r;
		push = i_in_valid && o_in_ready;
		pop = i_out_ready && o_out_valid;
		if (push) begin
			next_r.mem[r.wr_ptr] = i_in_data;
			next_r.wr_ptr = r.wr_ptr + PTR_W'(1);
		end
		if (pop) begin
			next_r.rd_ptr = r.rd_ptr + PTR_W'(1);
		end
		if (push && !pop) begin
			next_r.level = r.level + LVL_W'(1);
		end else if (pop && !push) begin
			next_r.level = r.level - LVL_W'(1);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule : sample_fifo

module spdif_tx_serial_input_formatter (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire spdif_in_pkg::apb_req_type i_apb,
	output spdif_in_pkg::apb_rsp_type o_apb,
	input wire logic i_bit_clock,
	input wire logic i_channel_select,
	input wire logic i_serial_data,
	input wire logic i_oversampling_clock,
	output logic o_biphase_tick
);
	import spdif_in_pkg::*;

	top_state_type r;
	top_state_type next_r;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [FIFO_W-1:0] fifo_out_data;
	logic [LEVEL_W-1:0] fifo_level;
	logic push;
	logic pop;

	always_comb begin
		logic bclk_rise;
		logic osc_rise;
		logic lr;
		logic lr_edge;
		logic prev_left;
		logic in_range;
		logic setup;
		logic access;
		logic ovf_set;
		logic ovf_clr;
		logic [5:0] cnt;
		logic [5:0] word_w;
		logic [5:0] msb_pos;
		logic [1:0] div;
		logic [SAMPLE_W-1:0] base;
		logic [DATA_W-1:0] rdata;
		logic mapped;
		next_r = r;
		bclk_rise = 1'b0;
		osc_rise = 1'b0;
		lr = 1'b0;
		lr_edge = 1'b0;
		prev_left = 1'b0;
		in_range = 1'b0;
		ovf_set = 1'b0;
		ovf_clr = 1'b0;
		cnt = '0;
		base = '0;
		rdata = '0;
		mapped = 1'b0;
		setup = 1'b0;
		access = 1'b0;
		word_w = WORD_16;
		msb_pos = '0;
		div = OS_DIV_256;
		push = 1'b0;
		pop = 1'b0;

		// first stage of each synchroniser feeds only the second
		next_r.bclk_sync = {r.bclk_sync[1:0], i_bit_clock};
		next_r.lr_sync = {r.lr_sync[0], i_channel_select};
		next_r.data_sync = {r.data_sync[0], i_serial_data};
		next_r.osc_sync = {r.osc_sync[1:0], i_oversampling_clock};
		bclk_rise = r.bclk_sync[1] && !r.bclk_sync[2];
		osc_rise = r.osc_sync[1] && !r.osc_sync[2];

		case (r.ctrl.width_sel)
			WSEL_16: word_w = WORD_16;
			WSEL_18: word_w = WORD_18;
			WSEL_20: word_w = WORD_20;
			WSEL_24: word_w = WORD_24;
			default: word_w = WORD_16;
		endcase
		case (r.ctrl.format)
			FMT_LEFT_JUST: msb_pos = 6'h00;
			FMT_RIGHT_JUST: msb_pos = HALF_FRAME_BITS - word_w;
			default: msb_pos = 6'h01;
		endcase

		// lr_prev tracks even while disabled, so enabling mid-word sees no false edge
		if (bclk_rise) begin
			lr = r.lr_sync[1];
			lr_edge = (lr != r.lr_prev);
			next_r.lr_prev = lr;
			// count saturates so a long half never wraps onto a word
			if (r.ctrl.enable) begin
				if (lr_edge) begin
					cnt = '0;
				end else if (r.bit_count == BIT_COUNT_MAX) begin
					cnt = BIT_COUNT_MAX;
				end else begin
					cnt = r.bit_count + 6'h01;
				end
				base = lr_edge ? '0 : r.shift;
				in_range = (cnt >= msb_pos) && (cnt < msb_pos + word_w);
				next_r.shift = in_range ? {base[SAMPLE_W-2:0], r.data_sync[1]} : base;
				next_r.bit_count = cnt;
				if (lr_edge) begin
					next_r.started = 1'b1;
					// I2S has left on low select, the justified modes on high
					prev_left = (r.ctrl.format == FMT_LEFT_JUST ||
						r.ctrl.format == FMT_RIGHT_JUST) ? r.lr_prev : !r.lr_prev;
					if (r.started) begin
						if (prev_left) begin
							next_r.left_word = r.shift;
							next_r.left_valid = 1'b1;
						end else if (r.left_valid) begin
							push = 1'b1;
							next_r.left_valid = 1'b0;
						end
					end
				end
			end
		end
		if (!r.ctrl.enable) begin
			next_r.started = 1'b0;
			next_r.left_valid = 1'b0;
			next_r.bit_count = '0;
		end
		ovf_set = push && !fifo_in_ready;

		// divider restarts when disabled, so the first tick is a whole period
		div = r.ctrl.ratio_384 ? OS_DIV_384 : OS_DIV_256;
		next_r.biphase_tick = 1'b0;
		if (osc_rise && r.ctrl.enable) begin
			if (r.div_count >= div - 2'h1) begin
				next_r.div_count = '0;
				next_r.biphase_tick = 1'b1;
			end else begin
				next_r.div_count = r.div_count + 2'h1;
			end
		end else if (!r.ctrl.enable) begin
			next_r.div_count = '0;
		end

		// answer is staged in the setup cycle, so pready and prdata leave flops
		setup = i_apb.psel && !i_apb.penable;
		access = i_apb.psel && i_apb.penable && r.rsp.pready;
		// empty fifo reads as zero, never a stale head
		case (i_apb.paddr)
			ADDR_CTRL: begin
				mapped = 1'b1;
				rdata = DATA_W'(r.ctrl);
			end
			ADDR_STATUS: begin
				mapped = 1'b1;
				rdata = DATA_W'({r.overflow, 9'h000, fifo_out_valid, fifo_level});
			end
			ADDR_LEFT: begin
				mapped = 1'b1;
				if (fifo_out_valid) begin
					rdata = DATA_W'(fifo_out_data[FIFO_W-1:SAMPLE_W]);
				end
			end
			ADDR_RIGHT: begin
				mapped = 1'b1;
				if (fifo_out_valid) begin
					rdata = DATA_W'(fifo_out_data[SAMPLE_W-1:0]);
				end
			end
			default: begin
				mapped = 1'b0;
				rdata = '0;
			end
		endcase
		next_r.rsp.pready = setup;
		next_r.rsp.prdata = setup ? rdata : '0;
		next_r.rsp.pslverr = setup && !mapped;
		// sample words are read only; writes there fall away
		if (access && i_apb.pwrite) begin
			case (i_apb.paddr)
				ADDR_CTRL: begin
					next_r.ctrl = ctrl_type'(i_apb.pwdata[CTRL_BITS-1:0]);
				end
				ADDR_STATUS: begin
					ovf_clr = i_apb.pwdata[STATUS_OVF_BIT];
				end
				default: begin
					ovf_clr = 1'b0;
				end
			endcase
		end
		// reading the right word retires the pair
		if (access && !i_apb.pwrite && i_apb.paddr == ADDR_RIGHT) begin
			pop = fifo_out_valid;
		end
		// a new overflow beats a clear in the same cycle
		next_r.overflow = (r.overflow && !ovf_clr) || ovf_set;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			r <= TOP_RESET;
		end else begin
			r <= next_r;
		end
	end

	// a full fifo refuses the pair; the drop shows as the overflow flag
	sample_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_DEPTH),
		.LVL_W(LEVEL_W)
	) u_fifo (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_in_valid(push),
		.o_in_ready(fifo_in_ready),
		.i_in_data({r.left_word, r.shift}),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(pop),
		.o_out_data(fifo_out_data),
		.o_level(fifo_level)
	);

	assign o_apb = r.rsp;
	assign o_biphase_tick = r.biphase_tick;
endmodule : spdif_tx_serial_input_formatter

`default_nettype wire

//--- verif/spdif_tx_props.sv
// port assertions of the serial input formatter
`timescale 1ns/10ps
`default_nettype none
module spdif_tx_props (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire spdif_in_pkg::apb_req_type i_apb,
	input wire spdif_in_pkg::apb_rsp_type o_apb,
	input wire logic i_oversampling_clock,
	input wire logic o_biphase_tick
);
	import spdif_in_pkg::*;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	logic osc_q;
	logic [2:0] rises;
	logic acc;
	assign acc = i_apb.psel && i_apb.penable && o_apb.pready;
	// raw rises seen since the last tick, saturating
	always_ff @(posedge i_clk_sys) begin
		osc_q <= i_oversampling_clock;
		if (i_srst || o_biphase_tick)
			rises <= 3'h0;
		else if (i_oversampling_clock && !osc_q && rises != 3'h7)
			rises <= rises + 3'h1;
	end
	sequence s_setup;
		i_apb.psel && !i_apb.penable;
	endsequence
	property p_ready_next;
		s_setup |=> o_apb.pready;
	endproperty
	a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
	property p_ready_pulse;
		o_apb.pready |=> !o_apb.pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
	property p_idle_zero;
		!o_apb.pready |-> o_apb.prdata == '0 && !o_apb.pslverr;
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("response outside access");
	property p_err_decode;
		acc && i_apb.paddr[1:0] == 2'h0 |-> o_apb.pslverr == (i_apb.paddr > ADDR_RIGHT);
	endproperty
	a_err_decode: assert property (p_err_decode) else $error("wrong error decode");
	property p_ctrl_bits;
		acc && !i_apb.pwrite && i_apb.paddr == ADDR_CTRL |-> o_apb.prdata[31:CTRL_BITS] == '0;
	endproperty
	a_ctrl_bits: assert property (p_ctrl_bits) else $error("ctrl spare bits set");
	property p_status_level;
		acc && !i_apb.pwrite && i_apb.paddr == ADDR_STATUS |-> o_apb.prdata[5:0] <= 6'h20
			&& o_apb.prdata[6] == (o_apb.prdata[5:0] != 6'h0);
	endproperty
	a_status_level: assert property (p_status_level) else $error("bad level");
	property p_tick_pulse;
		o_biphase_tick |=> !o_biphase_tick [*8];
	endproperty
	a_tick_pulse: assert property (p_tick_pulse) else $error("ticks too close");
	property p_tick_div;
		o_biphase_tick |-> rises >= 3'h2;
	endproperty
	a_tick_div: assert property (p_tick_div) else $error("tick divider short");
endmodule : spdif_tx_props
`default_nettype wire

//--- verif/serial_src.sv
// serial audio source model driving bit clock, select and data
`timescale 1ns/10ps
`default_nettype none
module serial_src (
	output logic o_bit_clock,
	output logic o_channel_select,
	output logic o_serial_data
);
	localparam logic [1:0] FMT_I2S_LVL = 2'h0;
	initial begin
		o_bit_clock = 1'b0;
		o_channel_select = 1'b0;
		o_serial_data = 1'b0;
	end
	// change after the fall, stable at the rise
	task automatic put(input logic lr, input logic d);
		o_channel_select = lr;
		o_serial_data = d;
		#200 o_bit_clock = 1'b1;
		#200 o_bit_clock = 1'b0;
	endtask : put
	task automatic burst(input logic [1:0] f, input int w, input int n, input logic [23:0] base);
		logic lft;
		int msb;
		logic [23:0] wd;
		lft = (f != FMT_I2S_LVL);
		msb = (f == 2'h1) ? 0 : (f == 2'h0) ? 1 : 32 - w;
		#13 put(!lft, 1'b0);
		for (int k = 0; k < 2 * n; k++) begin
			wd = k[0] ? ~(base + 24'(k / 2)) : base + 24'(k / 2);
			// idle slots toggle so stale bits never look valid
			for (int b = 0; b < 32; b++) begin
				put(lft ^ k[0], (b >= msb && b < msb + w) ? wd[w - 1 - b + msb] : b[0]);
			end
		end
		put(lft, 1'b0);
		o_serial_data = ~o_serial_data;
		#600;
	endtask : burst
endmodule : serial_src
`default_nettype wire

//--- verif/tb_spdif_tx_serial_input_formatter.sv
// testbench of the serial input formatter
`timescale 1ns/10ps
`default_nettype none
module tb_spdif_tx_serial_input_formatter;
	import spdif_in_pkg::*;
	logic i_clk_sys;
	logic i_srst;
	logic i_oversampling_clock;
	logic o_biphase_tick;
	logic bit_clock;
	logic channel_select;
	logic serial_data;
	apb_req_type req;
	apb_rsp_type rsp;
	int n_fail;
	int num_checks;
	int ticks = 0;
	logic [31:0] q;
	logic e;
	spdif_tx_serial_input_formatter dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_apb(req),
		.o_apb(rsp), .i_bit_clock(bit_clock), .i_channel_select(channel_select),
		.i_serial_data(serial_data), .i_oversampling_clock(i_oversampling_clock),
		.o_biphase_tick(o_biphase_tick));
	serial_src u_src (.o_bit_clock(bit_clock), .o_channel_select(channel_select),
		.o_serial_data(serial_data));
	initial begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		i_oversampling_clock = 1'b0;
		#7;
		forever #150 i_oversampling_clock = ~i_oversampling_clock;
	end
	always @(posedge i_clk_sys) begin
		if (o_biphase_tick === 1'b1)
			ticks++;
	end
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge i_clk_sys);
		req.penable <= 1'b1;
		do begin
			@(posedge i_clk_sys);
		end while (rsp.pready !== 1'b1);
		q = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
	endtask : apb
	task automatic cfg(input int f, input int ws, input int r, input int en);
		apb(1'b1, ADDR_CTRL, {26'h0, r[0], ws[1:0], f[1:0], en[0]});
	endtask : cfg
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	initial begin
		#3_000_000;
		n_fail++;
		complete_run();
	end
	initial begin
		int w;
		int d;
		logic [23:0] base;
		logic [23:0] m;
		i_srst = 1'b1;
		req = '0;
		n_fail = 0;
		num_checks = 0;
		repeat (12) @(posedge i_clk_sys);
		i_srst <= 1'b0;
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl", q, 32'h0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("status", q, 32'h0);
		apb(1'b1, 8'h10, 32'hFFFF);
		chk("err", {31'h0, e}, 32'h1);
		$display("test reset done");
		for (int f = 0; f < 3; f++) begin
			for (int ws = 0; ws < 4; ws++) begin
				w = (ws == 3) ? 24 : 16 + 2 * ws;
				m = 24'hFFFFFF >> (24 - w);
				base = 24'hC5A3E1 + 24'(f * 4 + ws) * 24'h111;
				cfg(f, ws, 0, 0);
				cfg(f, ws, 0, 1);
				u_src.burst(f[1:0], w, 1, base);
				apb(1'b0, ADDR_LEFT, 32'h0);
				chk("left", q, {8'h0, base & m});
				apb(1'b0, ADDR_RIGHT, 32'h0);
				chk("right", q, {8'h0, ~base & m});
				apb(1'b0, ADDR_STATUS, 32'h0);
				chk("level", q, 32'h0);
			end
		end
		$display("test formats done");
		cfg(1, 3, 0, 0);
		cfg(1, 3, 0, 1);
		base = 24'h13579B;
		u_src.burst(2'h1, 24, 33, base);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("full", q, 32'h0001_0060);
		apb(1'b1, ADDR_STATUS, 32'h0001_0000);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("cleared", q, 32'h0000_0060);
		for (int k = 0; k < 32; k++) begin
			apb(1'b0, ADDR_LEFT, 32'h0);
			chk("drain left", q, {8'h0, base + 24'(k)});
			apb(1'b0, ADDR_RIGHT, 32'h0);
			chk("drain right", q, {8'h0, ~(base + 24'(k))});
		end
		apb(1'b0, ADDR_RIGHT, 32'h0);
		chk("empty", q, 32'h0);
		$display("test fifo done");
		for (int r = 0; r < 2; r++) begin
			cfg(0, 0, r, 1);
			d = ticks;
			repeat (144) @(posedge i_clk_sys);
			d = ticks - d - (r == 1 ? 8 : 12);
			chk("ticks", {31'h0, d >= -1 && d <= 1}, 32'h1);
		end
		cfg(0, 0, 0, 0);
		repeat (2) @(posedge i_clk_sys);
		d = ticks;
		repeat (144) @(posedge i_clk_sys);
		chk("idle ticks", 32'(ticks - d), 32'h0);
		$display("test divider done");
		complete_run();
	end
endmodule : tb_spdif_tx_serial_input_formatter
bind spdif_tx_serial_input_formatter spdif_tx_props u_props (.i_clk_sys(i_clk_sys),
	.i_srst(i_srst), .i_apb(i_apb), .o_apb(o_apb),
	.i_oversampling_clock(i_oversampling_clock), .o_biphase_tick(o_biphase_tick));
`default_nettype wire
